// *** hdl/evp_unit.sv ***
// Event arbitration and handler address unit of the core.
// Assumes the partner holds each event until it is taken.
//
// Behaviour
// - Reset takes fixed vector, top priority, undefined return
// - Each exception has its own handler entry
// - Misses and supervisor call use enlarged areas
// - Protection violations: instruction or data, read/write split
// - No region hit raises matching miss exception
// - Several region hits raise multiple-hit error
// - Interrupt levels use controller-supplied autovector offset
// - Autovector offset is fourteen bits wide
// - Same instruction: best priority number wins
// - Oldest instruction's events are taken first
// - Debug stop jumps to debugger address
// - Fixed offsets for critical high-priority events
// - Return address kind follows event class
// - Floating-point, coprocessor, page-modified never raised
// - Software keeps handlers in protected memory
// - Software keeps autovectors off fixed entries
// - Target is base OR offset, no addition
// - Accepting an interrupt masks its own and lower levels plus gm; other exceptions except debug mask all interrupt levels
`timescale 1ns/100ps
`include "evp_defs.svh"

module evp_unit
  import evp_pkg::*;
(
  evp_if.unit io
);

  typedef struct packed {
    logic                 boot;
    logic                 take;
    logic [31:0]          vec_addr;
    logic [4:0]           prio;
    evp_ret_kind_t        ret_kind;
    logic [31:0]          ret_addr;
    logic [1:0]           take_stage;
    evp_mask_t            mask;
    logic                 irq_ack;
    logic [1:0]           irq_ack_lvl;
  } evp_unit_st_t;

  evp_unit_st_t st_q;
  evp_unit_st_t st_d;

  logic [`EVP_STAGES-1:0]    has_ev;
  logic [`EVP_STAGES-1:0][3:0] hcnt;
  logic [1:0]                vic;
  evp_stage_t                vs;
  logic                      miss;
  logic                      mhit;
  logic                      prot;
  logic [`EVP_NPRIO-1:0]     pend;
  logic [4:0]                win;

  // Counts the protection regions that claim one access
  function automatic logic [3:0] count_hits(input logic [`EVP_REGIONS-1:0] h);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < `EVP_REGIONS; i++)
    begin
      c = c + {3'h0, h[i]};
    end
    return c;
  endfunction

  // Fixed handler offset for a priority number
  function automatic logic [`EVP_AV_W-1:0] fixed_ofs(input logic [4:0] p);
    case (p)
      `EVP_P_UNREC:   return `EVP_OFS_UNREC;
      `EVP_P_MHIT:    return `EVP_OFS_MHIT;
      `EVP_P_BERR_D:  return `EVP_OFS_BERR_D;
      `EVP_P_BERR_I:  return `EVP_OFS_BERR_I;
      `EVP_P_NMI:     return `EVP_OFS_NMI;
      `EVP_P_IADDR:   return `EVP_OFS_IADDR;
      `EVP_P_IMISS:   return `EVP_OFS_IMISS;
      `EVP_P_IPROT:   return `EVP_OFS_IPROT;
      `EVP_P_BKPT:    return `EVP_OFS_BKPT;
      `EVP_P_ILLEG:   return `EVP_OFS_ILLEG;
      `EVP_P_UNIMP:   return `EVP_OFS_UNIMP;
      `EVP_P_PRIV:    return `EVP_OFS_PRIV;
      `EVP_P_FPU:     return `EVP_OFS_FPU;
      `EVP_P_COPRO:   return `EVP_OFS_COPRO;
      `EVP_P_SCALL:   return `EVP_OFS_SCALL;
      `EVP_P_DADDR_R: return `EVP_OFS_DADDR_R;
      `EVP_P_DADDR_W: return `EVP_OFS_DADDR_W;
      `EVP_P_DMISS_R: return `EVP_OFS_DMISS_R;
      `EVP_P_DMISS_W: return `EVP_OFS_DMISS_W;
      `EVP_P_DPROT_R: return `EVP_OFS_DPROT_R;
      `EVP_P_DPROT_W: return `EVP_OFS_DPROT_W;
      default:        return `EVP_OFS_DMOD;
    endcase
  endfunction

  // Return address class for a priority number
  function automatic evp_ret_kind_t ret_class(input logic [4:0] p);
    case (p)
      `EVP_P_DBG, `EVP_P_BERR_D, `EVP_P_BERR_I, `EVP_P_NMI, `EVP_P_BKPT:
        return EVP_RET_FIRST_NC;
      `EVP_P_SCALL:
        return EVP_RET_SCALL_NEXT;
      default:
        if (p >= `EVP_P_INT3 && p <= `EVP_P_INT0)
          return EVP_RET_FIRST_NC;
        else
          return EVP_RET_OFFENDING;
    endcase
  endfunction

  // Per-stage event presence and region hit counts
  generate
    for (genvar s = 0; s < `EVP_STAGES; s++)
    begin : g_stage
      assign hcnt[s] = count_hits(io.stage[s].hit);
      assign has_ev[s] = io.stage[s].valid &&
        (io.stage[s].iaddr || io.stage[s].bkpt || io.stage[s].illegal ||
         io.stage[s].unimpl || io.stage[s].priv || io.stage[s].scall ||
         io.stage[s].daddr_r || io.stage[s].daddr_w ||
         (io.stage[s].acc_v && (hcnt[s] != 4'h1 || !io.stage[s].perm_ok)));
    end
  endgenerate

  // Oldest stage with an event is the victim; stage 0 when none has
  always_comb
  begin
    vic = 2'd0;
    for (int s = `EVP_STAGES - 1; s >= 0; s--)
    begin
      if (has_ev[s])
        vic = 2'(s);
    end
  end

  assign vs   = io.stage[vic];
  assign miss = vs.valid && vs.acc_v && (hcnt[vic] == 4'h0);
  assign mhit = vs.valid && vs.acc_v && (hcnt[vic] > 4'h1);
  assign prot = vs.valid && vs.acc_v && (hcnt[vic] == 4'h1) && !vs.perm_ok;

  // Pending vector, bit p-1 for priority p
  always_comb
  begin
    pend = '0;
    pend[`EVP_P_DBG-1]     = io.dbg_req && !st_q.mask.dm;
    pend[`EVP_P_UNREC-1]   = io.unrec;
    pend[`EVP_P_MHIT-1]    = mhit;
    pend[`EVP_P_BERR_D-1]  = io.berr_d;
    pend[`EVP_P_BERR_I-1]  = io.berr_i;
    pend[`EVP_P_NMI-1]     = io.nmi;
    for (int k = 0; k < 4; k++)
    begin
      pend[`EVP_P_INT0-1-k] = io.irq[k] && !st_q.mask.gm && !st_q.mask.im[k];
    end
    pend[`EVP_P_IADDR-1]   = vs.valid && vs.iaddr;
    pend[`EVP_P_IMISS-1]   = miss && !vs.acc_data;
    pend[`EVP_P_IPROT-1]   = prot && !vs.acc_data;
    pend[`EVP_P_BKPT-1]    = vs.valid && vs.bkpt;
    pend[`EVP_P_ILLEG-1]   = vs.valid && vs.illegal;
    pend[`EVP_P_UNIMP-1]   = vs.valid && vs.unimpl;
    pend[`EVP_P_PRIV-1]    = vs.valid && vs.priv;
    pend[`EVP_P_SCALL-1]   = vs.valid && vs.scall;
    pend[`EVP_P_DADDR_R-1] = vs.valid && vs.daddr_r;
    pend[`EVP_P_DADDR_W-1] = vs.valid && vs.daddr_w;
    pend[`EVP_P_DMISS_R-1] = miss && vs.acc_data && !vs.acc_wr;
    pend[`EVP_P_DMISS_W-1] = miss && vs.acc_data && vs.acc_wr;
    pend[`EVP_P_DPROT_R-1] = prot && vs.acc_data && !vs.acc_wr;
    pend[`EVP_P_DPROT_W-1] = prot && vs.acc_data && vs.acc_wr;
    // No floating-point, coprocessor or paging hardware
    pend[`EVP_P_FPU-1]     = 1'b0;
    pend[`EVP_P_COPRO-1]   = 1'b0;
    pend[`EVP_P_DMOD-1]    = 1'b0;
  end

  // Best priority number among the pending ones, 0 when idle
  always_comb
  begin
    win = 5'd0;
    for (int p = `EVP_NPRIO; p >= 1; p--)
    begin
      if (pend[p-1])
        win = 5'(p);
    end
  end

  always_comb
  begin
    st_d = st_q;
    st_d.take = 1'b0;
    st_d.irq_ack = 1'b0;
    st_d.boot = 1'b0;
    if (io.mask_wr)
      st_d.mask = io.mask_wdata;
    if (st_q.boot)
    begin
      st_d.take       = 1'b1;
      st_d.vec_addr   = `EVP_RESET_VEC;
      st_d.prio       = 5'd1;
      st_d.ret_kind   = EVP_RET_UNDEF;
      st_d.ret_addr   = '0;
      st_d.take_stage = 2'd0;
    end
    // One idle cycle after a take lets the pipeline flush
    else if (win != 5'd0 && !st_q.take)
    begin
      st_d.take       = 1'b1;
      st_d.prio       = win;
      st_d.take_stage = vic;
      st_d.ret_kind   = ret_class(win);
      case (ret_class(win))
        EVP_RET_SCALL_NEXT: st_d.ret_addr = vs.pc + `EVP_SCALL_STEP;
        default:            st_d.ret_addr = vs.pc;
      endcase
      if (win == `EVP_P_DBG)
      begin
        st_d.vec_addr = io.dbg_addr;
        st_d.mask.dm  = 1'b1;
      end
      else if (win >= `EVP_P_INT3 && win <= `EVP_P_INT0)
      begin
        st_d.vec_addr    = io.event_vector_base | {18'h0, io.irq_ofs};
        st_d.irq_ack     = 1'b1;
        st_d.irq_ack_lvl = 2'(`EVP_P_INT0 - win);
        st_d.mask.gm     = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
          if (k <= 32'(`EVP_P_INT0 - win))
            st_d.mask.im[k] = 1'b1;
        end
      end
      else
      begin
        st_d.vec_addr = io.event_vector_base | {18'h0, fixed_ofs(win)};
        st_d.mask.gm  = 1'b1;
        st_d.mask.em  = 1'b1;
        st_d.mask.im  = 4'hF;
      end
    end
  end

  always_ff @(posedge io.clk or negedge io.nrst)
  begin
    if (!io.nrst)
    begin
      st_q      <= '0;
      st_q.boot <= 1'b1;
      st_q.mask <= '{dm: 1'b0, gm: 1'b1, em: 1'b1, im: 4'hF};
    end
    else
      st_q <= st_d;
  end

  assign io.take        = st_q.take;
  assign io.vec_addr    = st_q.vec_addr;
  assign io.prio        = st_q.prio;
  assign io.ret_kind    = st_q.ret_kind;
  assign io.ret_addr    = st_q.ret_addr;
  assign io.take_stage  = st_q.take_stage;
  assign io.mask        = st_q.mask;
  assign io.irq_ack     = st_q.irq_ack;
  assign io.irq_ack_lvl = st_q.irq_ack_lvl;

endmodule

// *** hdl/evp_defs.svh ***
// Constants for the event vector and priority unit.
// Assumes inclusion by bare name from every file that needs them.
`ifndef EVP_DEFS_SVH
`define EVP_DEFS_SVH

`define EVP_RESET_VEC   32'h8000_0000
`define EVP_STAGES      3
`define EVP_REGIONS     8
`define EVP_NPRIO       28
`define EVP_AV_W        14
// Handler offsets relative to the event vector base
`define EVP_OFS_UNREC   14'h0000
`define EVP_OFS_MHIT    14'h0004
`define EVP_OFS_BERR_D  14'h0008
`define EVP_OFS_BERR_I  14'h000C
`define EVP_OFS_NMI     14'h0010
`define EVP_OFS_IADDR   14'h0014
`define EVP_OFS_IPROT   14'h0018
`define EVP_OFS_BKPT    14'h001C
`define EVP_OFS_ILLEG   14'h0020
`define EVP_OFS_UNIMP   14'h0024
`define EVP_OFS_PRIV    14'h0028
`define EVP_OFS_FPU     14'h002C
`define EVP_OFS_COPRO   14'h0030
`define EVP_OFS_DADDR_R 14'h0034
`define EVP_OFS_DADDR_W 14'h0038
`define EVP_OFS_DPROT_R 14'h003C
`define EVP_OFS_DPROT_W 14'h0040
`define EVP_OFS_DMOD    14'h0044
`define EVP_OFS_IMISS   14'h0050
`define EVP_OFS_DMISS_R 14'h0060
`define EVP_OFS_DMISS_W 14'h0070
`define EVP_OFS_SCALL   14'h0100
// Priority numbers, 1 best
`define EVP_P_DBG       5'd2
`define EVP_P_UNREC     5'd3
`define EVP_P_MHIT      5'd4
`define EVP_P_BERR_D    5'd5
`define EVP_P_BERR_I    5'd6
`define EVP_P_NMI       5'd7
`define EVP_P_INT3      5'd8
`define EVP_P_INT0      5'd11
`define EVP_P_IADDR     5'd12
`define EVP_P_IMISS     5'd13
`define EVP_P_IPROT     5'd14
`define EVP_P_BKPT      5'd15
`define EVP_P_ILLEG     5'd16
`define EVP_P_UNIMP     5'd17
`define EVP_P_PRIV      5'd18
`define EVP_P_FPU       5'd19
`define EVP_P_COPRO     5'd20
`define EVP_P_SCALL     5'd21
`define EVP_P_DADDR_R   5'd22
`define EVP_P_DADDR_W   5'd23
`define EVP_P_DMISS_R   5'd24
`define EVP_P_DMISS_W   5'd25
`define EVP_P_DPROT_R   5'd26
`define EVP_P_DPROT_W   5'd27
`define EVP_P_DMOD      5'd28
`define EVP_SCALL_STEP  32'h0000_0002
`endif

// *** hdl/evp_pkg.sv ***
// Types shared by both ends of the event vector and priority unit.
// Assumes evp_defs.svh is on the include path.
`include "evp_defs.svh"

package evp_pkg;

  typedef enum logic [1:0] {
    EVP_RET_UNDEF,
    EVP_RET_FIRST_NC,
    EVP_RET_OFFENDING,
    EVP_RET_SCALL_NEXT
  } evp_ret_kind_t;

  // Events raised by one instruction in one pipeline stage
  typedef struct packed {
    logic                      valid;
    logic [31:0]               pc;
    logic                      iaddr;
    logic                      bkpt;
    logic                      illegal;
    logic                      unimpl;
    logic                      priv;
    logic                      scall;
    logic                      daddr_r;
    logic                      daddr_w;
    logic                      acc_v;
    logic                      acc_data;
    logic                      acc_wr;
    logic [`EVP_REGIONS-1:0]   hit;
    logic                      perm_ok;
  } evp_stage_t;

  typedef struct packed {
    logic       dm;
    logic       gm;
    logic       em;
    logic [3:0] im;
  } evp_mask_t;

endpackage

// *** hdl/evp_if.sv ***
// Link between the event unit and its controller / pipeline partner.
// Both ends share clk and nrst; stage 0 is the oldest instruction.
`timescale 1ns/100ps
`include "evp_defs.svh"

interface evp_if
  import evp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst
);
  logic [31:0]                event_vector_base;
  logic                       dbg_req;
  logic [31:0]                dbg_addr;
  logic                       unrec;
  logic                       berr_d;
  logic                       berr_i;
  logic                       nmi;
  logic [3:0]                 irq;
  logic [`EVP_AV_W-1:0]       irq_ofs;
  evp_stage_t [`EVP_STAGES-1:0] stage;
  logic                       mask_wr;
  evp_mask_t                  mask_wdata;
  logic                       take;
  logic [31:0]                vec_addr;
  logic [4:0]                 prio;
  evp_ret_kind_t              ret_kind;
  logic [31:0]                ret_addr;
  logic [1:0]                 take_stage;
  evp_mask_t                  mask;
  logic                       irq_ack;
  logic [1:0]                 irq_ack_lvl;

  modport unit (
    input  clk, nrst, event_vector_base, dbg_req, dbg_addr, unrec, berr_d, berr_i,
           nmi, irq, irq_ofs, stage, mask_wr, mask_wdata,
    output take, vec_addr, prio, ret_kind, ret_addr, take_stage, mask, irq_ack,
           irq_ack_lvl
  );

  modport partner (
    input  clk, nrst, take, vec_addr, prio, ret_kind, ret_addr, take_stage, mask,
           irq_ack, irq_ack_lvl,
    output event_vector_base, dbg_req, dbg_addr, unrec, berr_d, berr_i, nmi, irq,
           irq_ofs, stage, mask_wr, mask_wdata
  );
endinterface

// *** hdl/evp_partner.sv ***
// Partner end: interrupt level controller plus pipeline event feed.
// Assumes user ports come from logic on the same clock.
`timescale 1ns/100ps
`include "evp_defs.svh"

module evp_partner
  import evp_pkg::*;
(
  evp_if.partner                         io,
  input  wire logic [31:0]               base,
  input  wire logic [3:0]                irq_lines,
  input  wire logic [3:0][`EVP_AV_W-1:0] irq_vec,
  input  wire logic                      dbg_stop,
  input  wire logic [31:0]               dbg_handler,
  input  wire logic                      unrec_in,
  input  wire logic                      berr_d_in,
  input  wire logic                      berr_i_in,
  input  wire logic                      nmi_in,
  input  wire evp_stage_t [`EVP_STAGES-1:0] stage_in,
  input  wire logic                      mask_wr_in,
  input  wire evp_mask_t                 mask_wdata_in,
  output logic                           taken,
  output logic [31:0]                    taken_addr,
  output evp_ret_kind_t                  taken_kind,
  output logic [31:0]                    taken_ret
);

  typedef struct packed {
    logic [31:0]                  base;
    logic [3:0]                   irq;
    logic [`EVP_AV_W-1:0]         ofs;
    logic                         dbg;
    logic [31:0]                  dbg_addr;
    logic                         unrec;
    logic                         berr_d;
    logic                         berr_i;
    logic                         nmi;
    evp_stage_t [`EVP_STAGES-1:0] stage;
    logic                         mask_wr;
    evp_mask_t                    mask_wdata;
    logic                         taken;
    logic [31:0]                  taken_addr;
    evp_ret_kind_t                taken_kind;
    logic [31:0]                  taken_ret;
  } evp_part_st_t;

  evp_part_st_t st_q;
  evp_part_st_t st_d;
  evp_mask_t    eff_mask;

  // Mask the unit holds when this offset is used; a pending write wins
  assign eff_mask = st_q.mask_wr ? st_q.mask_wdata : io.mask;

  // Offset of the highest unmasked requesting level, level 3 best
  always_comb
  begin
    st_d = st_q;
    st_d.base       = base;
    st_d.irq        = irq_lines;
    st_d.ofs        = '0;
    for (int k = 0; k < 4; k++)
    begin
      if (irq_lines[k] && !eff_mask.im[k])
        st_d.ofs = irq_vec[k];
    end
    st_d.dbg        = dbg_stop;
    st_d.dbg_addr   = dbg_handler;
    st_d.unrec      = unrec_in;
    st_d.berr_d     = berr_d_in;
    st_d.berr_i     = berr_i_in;
    st_d.nmi        = nmi_in;
    st_d.stage      = stage_in;
    st_d.mask_wr    = mask_wr_in;
    st_d.mask_wdata = mask_wdata_in;
    st_d.taken      = io.take;
    st_d.taken_addr = io.vec_addr;
    st_d.taken_kind = io.ret_kind;
    st_d.taken_ret  = io.ret_addr;
  end

  always_ff @(posedge io.clk or negedge io.nrst)
  begin
    if (!io.nrst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign io.event_vector_base = st_q.base;
  assign io.irq               = st_q.irq;
  assign io.irq_ofs           = st_q.ofs;
  assign io.dbg_req           = st_q.dbg;
  assign io.dbg_addr          = st_q.dbg_addr;
  assign io.unrec             = st_q.unrec;
  assign io.berr_d            = st_q.berr_d;
  assign io.berr_i            = st_q.berr_i;
  assign io.nmi               = st_q.nmi;
  assign io.stage             = st_q.stage;
  assign io.mask_wr           = st_q.mask_wr;
  assign io.mask_wdata        = st_q.mask_wdata;
  assign taken                = st_q.taken;
  assign taken_addr           = st_q.taken_addr;
  assign taken_kind           = st_q.taken_kind;
  assign taken_ret            = st_q.taken_ret;

endmodule

// *** verification/evp_properties.sv ***
// Checker for the link between the event unit and its partner.
// Assumes one clock and an asynchronous active-low reset on the link.
`timescale 1ns/100ps
module evp_properties
  import evp_pkg::*;
(
  input wire logic          clk,
  input wire logic          nrst,
  input wire logic [31:0]   event_vector_base,
  input wire logic [31:0]   dbg_addr,
  input wire logic [3:0]    irq,
  input wire logic [13:0]   irq_ofs,
  input wire logic          take,
  input wire logic [31:0]   vec_addr,
  input wire logic [4:0]    prio,
  input wire evp_ret_kind_t ret_kind,
  input wire evp_mask_t     mask,
  input wire logic          irq_ack,
  input wire logic [1:0]    irq_ack_lvl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_take_gap:
    assert property (take |=> !take) else $error("take held two cycles");
  a_reset_entry:
    assert property (take && prio == 5'd1 |-> vec_addr == 32'h8000_0000
      && ret_kind == EVP_RET_UNDEF) else $error("reset entry wrong");
  a_unused_prio:
    assert property (take |-> !(prio inside {5'd19, 5'd20, 5'd28}))
    else $error("unused event raised");
  a_nmi_entry:
    assert property (take && prio == 5'd7 |-> vec_addr == ($past(event_vector_base)
      | 32'h0000_0010) && ret_kind == EVP_RET_FIRST_NC) else $error("nmi entry wrong");
  a_irq_vector:
    assert property (take && irq_ack |-> vec_addr == ($past(event_vector_base)
      | {18'h0_0000, $past(irq_ofs)})) else $error("autovector wrong");
  // Masked higher levels must not count against the taken level
  a_irq_level:
    assert property (take && irq_ack |-> (($past(irq) & ~$past(mask.im)) >> irq_ack_lvl)
      == 4'h1 && prio == 5'd11 - 5'(irq_ack_lvl)) else $error("wrong level taken");
  a_ack_with_take:
    assert property (irq_ack |-> take && prio inside {[5'd8:5'd11]})
    else $error("ack without interrupt take");
  a_irq_mask:
    assert property (take && irq_ack |-> mask.gm
      && ((~mask.im) & (4'hF >> (2'd3 - irq_ack_lvl))) == 4'h0)
    else $error("interrupt mask not set");
  a_exc_mask:
    assert property (take && prio inside {[5'd3:5'd7]} |-> mask.gm && mask.em
      && mask.im == 4'hF) else $error("exception mask not set");
  a_dbg_entry:
    assert property (take && prio == 5'd2 |-> vec_addr == $past(dbg_addr) && mask.dm)
    else $error("debug entry wrong");
endmodule

// *** verification/test_exception_vector_priority.sv ***
// Testbench: unit and partner joined by the link, driven from the partner's user side.
// Assumes evp_defs.svh on the include path; inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
`include "evp_defs.svh"
module test_exception_vector_priority
  import evp_pkg::*;
();
  localparam logic [31:0] PC0 = 32'h0000_2000;
  logic             clk;
  logic             nrst;
  logic [31:0]      base;
  logic [3:0]       irq_l;
  logic [3:0][13:0] irq_v;
  logic             dbg_stop;
  logic [31:0]      dbg_h;
  logic             unrec;
  logic             berr_d;
  logic             berr_i;
  logic             nmi;
  evp_stage_t [2:0] st;
  logic             mask_wr;
  evp_mask_t        mask_wd;
  logic             taken;
  logic [31:0]      taken_addr;
  evp_ret_kind_t    taken_kind;
  logic [31:0]      taken_ret;
  int               num_errors = 0;
  int               n_compared = 0;
  int               cyc = 0;

  evp_if i_evp_if (.clk(clk), .nrst(nrst));
  evp_unit i_evp_unit (.io(i_evp_if));
  evp_partner i_evp_partner (.io(i_evp_if), .base(base), .irq_lines(irq_l), .irq_vec(irq_v),
    .dbg_stop(dbg_stop), .dbg_handler(dbg_h), .unrec_in(unrec), .berr_d_in(berr_d),
    .berr_i_in(berr_i), .nmi_in(nmi), .stage_in(st), .mask_wr_in(mask_wr),
    .mask_wdata_in(mask_wd), .taken(taken), .taken_addr(taken_addr),
    .taken_kind(taken_kind), .taken_ret(taken_ret));
  evp_properties i_evp_properties (.clk(clk), .nrst(nrst),
    .event_vector_base(i_evp_if.event_vector_base), .dbg_addr(i_evp_if.dbg_addr),
    .irq(i_evp_if.irq), .irq_ofs(i_evp_if.irq_ofs), .take(i_evp_if.take),
    .vec_addr(i_evp_if.vec_addr), .prio(i_evp_if.prio), .ret_kind(i_evp_if.ret_kind),
    .mask(i_evp_if.mask), .irq_ack(i_evp_if.irq_ack), .irq_ack_lvl(i_evp_if.irq_ack_lvl));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // Drop every request; stages valid, one region hit, permission granted
  task automatic idle();
    unrec = 1'b0;
    berr_d = 1'b0;
    berr_i = 1'b0;
    nmi = 1'b0;
    irq_l = 4'h0;
    dbg_stop = 1'b0;
    mask_wr = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      st[i] = '0;
      st[i].valid = 1'b1;
      st[i].pc = PC0 + 32'(4 * i);
      st[i].hit = 8'h01;
      st[i].perm_ok = 1'b1;
    end
  endtask

  // Kind UNDEF means return kind and address are not judged
  task automatic expect_take(input logic [31:0] v, input logic [4:0] p,
                             input evp_ret_kind_t k, input logic [31:0] r);
    int n;
    n = 0;
    tick();
    while (i_evp_if.take !== 1'b1 && n < 8)
    begin
      tick();
      n++;
    end
    chk(i_evp_if.take === 1'b1 && i_evp_if.vec_addr === v, "take or vector");
    chk(i_evp_if.prio === p, "priority");
    if (k != EVP_RET_UNDEF)
      chk(i_evp_if.ret_kind === k && i_evp_if.ret_addr === r, "return point");
    idle();
    tick();
    chk(taken === 1'b1 && taken_addr === v && taken_kind === i_evp_if.ret_kind
        && taken_ret === i_evp_if.ret_addr, "copy");
    tick();
    tick();
  endtask

  task automatic expect_none(input int n);
    repeat (n)
    begin
      tick();
      chk(i_evp_if.take === 1'b0, "unexpected take");
    end
  endtask

  task automatic set_mask(input evp_mask_t m);
    mask_wd = m;
    mask_wr = 1'b1;
    tick();
    mask_wr = 1'b0;
    tick();
    tick();
    chk(i_evp_if.mask === m, "mask write");
  endtask

  task automatic access(input logic d, input logic w, input logic [7:0] h, input logic ok);
    st[0].acc_v = 1'b1;
    st[0].acc_data = d;
    st[0].acc_wr = w;
    st[0].hit = h;
    st[0].perm_ok = ok;
  endtask

  task automatic t_reset();
    repeat (3) @(posedge clk);
    chk(i_evp_if.mask === 7'h3F, "mask reset value");
    #1 nrst = 1'b1;
    tick();
    chk(i_evp_if.take === 1'b1 && i_evp_if.vec_addr === 32'h8000_0000, "reset entry");
    chk(i_evp_if.prio === 5'd1 && i_evp_if.ret_kind === EVP_RET_UNDEF, "reset kind");
    tick();
    tick();
  endtask

  task automatic t_globals();
    unrec = 1'b1;
    expect_take(base | 32'h0000_0000, 5'd3, EVP_RET_OFFENDING, PC0);
    berr_d = 1'b1;
    expect_take(base | 32'h0000_0008, 5'd5, EVP_RET_FIRST_NC, PC0);
    berr_i = 1'b1;
    expect_take(base | 32'h0000_000C, 5'd6, EVP_RET_FIRST_NC, PC0);
    nmi = 1'b1;
    expect_take(base | 32'h0000_0010, 5'd7, EVP_RET_FIRST_NC, PC0);
  endtask

  task automatic t_stage();
    st[0].iaddr = 1'b1;
    expect_take(base | 32'h0000_0014, 5'd12, EVP_RET_OFFENDING, PC0);
    st[0].bkpt = 1'b1;
    expect_take(base | 32'h0000_001C, 5'd15, EVP_RET_FIRST_NC, PC0);
    st[0].illegal = 1'b1;
    expect_take(base | 32'h0000_0020, 5'd16, EVP_RET_OFFENDING, PC0);
    st[0].unimpl = 1'b1;
    expect_take(base | 32'h0000_0024, 5'd17, EVP_RET_OFFENDING, PC0);
    st[0].priv = 1'b1;
    expect_take(base | 32'h0000_0028, 5'd18, EVP_RET_OFFENDING, PC0);
    st[0].scall = 1'b1;
    expect_take(base | 32'h0000_0100, 5'd21, EVP_RET_SCALL_NEXT, PC0 + 32'h0000_0002);
    st[0].daddr_r = 1'b1;
    expect_take(base | 32'h0000_0034, 5'd22, EVP_RET_OFFENDING, PC0);
    st[0].daddr_w = 1'b1;
    expect_take(base | 32'h0000_0038, 5'd23, EVP_RET_OFFENDING, PC0);
  endtask

  task automatic t_access();
    access(1'b0, 1'b0, 8'h00, 1'b1);
    expect_take(base | 32'h0000_0050, 5'd13, EVP_RET_UNDEF, PC0);
    access(1'b1, 1'b0, 8'h00, 1'b1);
    expect_take(base | 32'h0000_0060, 5'd24, EVP_RET_UNDEF, PC0);
    access(1'b1, 1'b1, 8'h00, 1'b1);
    expect_take(base | 32'h0000_0070, 5'd25, EVP_RET_UNDEF, PC0);
    access(1'b1, 1'b0, 8'h81, 1'b1);
    expect_take(base | 32'h0000_0004, 5'd4, EVP_RET_UNDEF, PC0);
    access(1'b0, 1'b0, 8'h04, 1'b0);
    expect_take(base | 32'h0000_0018, 5'd14, EVP_RET_OFFENDING, PC0);
    access(1'b1, 1'b0, 8'h10, 1'b0);
    expect_take(base | 32'h0000_003C, 5'd26, EVP_RET_OFFENDING, PC0);
    access(1'b1, 1'b1, 8'h10, 1'b0);
    expect_take(base | 32'h0000_0040, 5'd27, EVP_RET_OFFENDING, PC0);
    access(1'b1, 1'b1, 8'h02, 1'b1);
    expect_none(5);
    idle();
  endtask

  task automatic t_prio();
    st[0].illegal = 1'b1;
    st[0].priv = 1'b1;
    st[0].bkpt = 1'b1;
    expect_take(base | 32'h0000_001C, 5'd15, EVP_RET_FIRST_NC, PC0);
    nmi = 1'b1;
    berr_i = 1'b1;
    st[0].iaddr = 1'b1;
    expect_take(base | 32'h0000_000C, 5'd6, EVP_RET_FIRST_NC, PC0);
  endtask

  task automatic t_oldest();
    st[0].daddr_w = 1'b1;
    st[1].iaddr = 1'b1;
    expect_take(base | 32'h0000_0038, 5'd23, EVP_RET_OFFENDING, PC0);
    chk(i_evp_if.take_stage === 2'd0, "oldest stage");
    st[1].illegal = 1'b1;
    expect_take(base | 32'h0000_0020, 5'd16, EVP_RET_OFFENDING, PC0 + 32'h0000_0004);
    chk(i_evp_if.take_stage === 2'd1, "younger stage");
  endtask

  // Overlapping bits tell OR apart from addition
  task automatic t_or();
    base = 32'h9000_0114;
    nmi = 1'b1;
    expect_take(32'h9000_0114, 5'd7, EVP_RET_FIRST_NC, PC0);
    base = 32'h9000_0000;
  endtask

  task automatic t_debug();
    dbg_stop = 1'b1;
    expect_take(dbg_h, 5'd2, EVP_RET_FIRST_NC, PC0);
    chk(i_evp_if.mask.dm === 1'b1, "debug mask");
    dbg_stop = 1'b1;
    expect_none(6);
    idle();
  endtask

  task automatic t_irq();
    for (int k = 0; k < 4; k++)
    begin
      set_mask({1'b0, 1'b0, 1'b1, 4'h0});
      irq_l = 4'h1 << k;
      expect_take(base | {18'h0_0000, irq_v[k]}, 5'd11 - 5'(k), EVP_RET_FIRST_NC, PC0);
      chk(i_evp_if.mask.im === 4'((2 << k) - 1) && i_evp_if.mask.gm === 1'b1, "lvl mask");
    end
    set_mask({1'b0, 1'b0, 1'b1, 4'h0});
    irq_l = 4'h6;
    expect_take(base | {18'h0_0000, irq_v[2]}, 5'd9, EVP_RET_FIRST_NC, PC0);
    set_mask({1'b0, 1'b0, 1'b1, 4'h8});
    irq_l = 4'h8;
    expect_none(6);
    irq_l = 4'h9;
    expect_take(base | {18'h0_0000, irq_v[0]}, 5'd11, EVP_RET_FIRST_NC, PC0);
    set_mask({1'b0, 1'b1, 1'b1, 4'h0});
    irq_l = 4'h1;
    expect_none(6);
    idle();
  endtask

  initial
  begin
    nrst = 1'b0;
    base = 32'h9000_0000;
    irq_v = {14'h3FFC, 14'h0200, 14'h0180, 14'h0120};
    dbg_h = 32'h00C0_FFE0;
    mask_wd = '0;
    idle();
    t_reset();
    t_globals();
    t_stage();
    t_access();
    t_prio();
    t_oldest();
    t_or();
    t_debug();
    t_irq();
    final_report();
  end
endmodule
